// ### ccm_edge.sv
/*
 * ccm_edge: synchroniser and edge detector for the unit's input pin.
 * assumes: pin is asynchronous to clk_i; single clock, sync reset.
 */
`timescale 1ns/1ps
module ccm_edge (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// pin and edges
	input  wire logic pin_i,
	output logic      rise_o,
	output logic      fall_o
);
	logic sync1_ff;
	logic sync2_ff;
	logic last_ff;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
			last_ff  <= 1'b0;
		end else begin
			sync1_ff <= pin_i;
			sync2_ff <= sync1_ff;
			last_ff  <= sync2_ff;
		end
	end

	assign rise_o = sync2_ff & ~last_ff;
	assign fall_o = ~sync2_ff & last_ff;
endmodule

// ### ccm_far_model.sv
/*
 * ccm_far_model: period timer standing beside the capture/compare unit.
 * assumes: shares clk_i and the synchronous reset with the unit.
 */
`timescale 1ns/1ps
module ccm_far_model #(
	parameter int P = 10
) (
	// clock and reset
	input  wire logic   clk_i,
	input  wire logic   rst_i,
	// period timer
	output logic [15:0] period_timer_o,
	output logic        period_reload_o
);
	// free running, wraps after P counts
	always_ff @(posedge clk_i) begin
		if (rst_i || period_timer_o == 16'(P - 1)) begin
			period_timer_o <= 16'h0000;
		end else begin
			period_timer_o <= period_timer_o + 16'h0001;
		end
	end
	// reload pulse at start of each period
	assign period_reload_o = (period_timer_o == 16'h0000);
endmodule

// ### ccm_pkg.sv
/*
 * ccm_pkg: constants and types for the capture/compare/PWM mode unit.
 * assumes: nothing; imported by no file, referenced by scope only.
 */
package ccm_pkg;
	localparam int          CCM_TMR_W      = 16;
	localparam int          CCM_MODE_W     = 4;
	localparam int          CCM_MODE_LSB   = 0;
	localparam logic [3:0]  CCM_MODE_OFF   = 4'h0;
	localparam logic [3:0]  CCM_MODE_TGLCL = 4'h1;
	localparam logic [3:0]  CCM_MODE_TGL   = 4'h2;
	localparam logic [3:0]  CCM_MODE_CAPBO = 4'h3;
	localparam logic [3:0]  CCM_MODE_CAPFA = 4'h4;
	localparam logic [3:0]  CCM_MODE_CAPRI = 4'h5;
	localparam logic [3:0]  CCM_MODE_CAP4  = 4'h6;
	localparam logic [3:0]  CCM_MODE_CAP16 = 4'h7;
	localparam logic [3:0]  CCM_MODE_SET   = 4'h8;
	localparam logic [3:0]  CCM_MODE_CLR   = 4'h9;
	localparam logic [3:0]  CCM_MODE_PLS   = 4'hA;
	localparam logic [3:0]  CCM_MODE_PLSCL = 4'hB;
	localparam logic [3:0]  CCM_MODE_PWM   = 4'hC;
	localparam logic [3:0]  CCM_MODE_RSV0  = 4'hD;
	localparam logic [3:0]  CCM_MODE_RSV1  = 4'hE;
	localparam logic [3:0]  CCM_MODE_PWM2  = 4'hF;
	localparam logic [3:0]  CCM_PRE4_LAST  = 4'h3;
	localparam logic [3:0]  CCM_PRE16_LAST = 4'hF;
	localparam logic [15:0] CCM_TMR_RST    = 16'h0000;

	typedef enum logic [2:0] {
		CCM_KIND_OFF = 3'b000,
		CCM_KIND_CAP = 3'b001,
		CCM_KIND_CMP = 3'b010,
		CCM_KIND_PWM = 3'b011,
		CCM_KIND_RSV = 3'b100
	} ccm_kind_type;

	// per-mode decoded behaviour
	typedef struct packed {
		ccm_kind_type kind;
		logic         cap_rise;
		logic         cap_fall;
		logic [3:0]   pre_last;
		logic         clr_tmr;
		logic         pulse;
	} ccm_dec_type;

	// events leaving the unit
	typedef struct packed {
		logic capture;
		logic match;
		logic pwm_edge;
	} ccm_evt_type;
endpackage

// ### ccm_pwm.sv
/*
 * ccm_pwm: pwm waveform from the period timer count and a duty value.
 * assumes: period timer count and period-reload pulse come from the same clock.
 */
`timescale 1ns/1ps
module ccm_pwm #(
	parameter int W = 16
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// control
	input  wire logic         en_i,
	input  wire logic [W-1:0] duty_i,
	// period timer
	input  wire logic [W-1:0] ptmr_i,
	input  wire logic         prd_i,
	// result
	output logic              pwm_o,
	output logic              edge_o
);
	logic [W-1:0] duty_ff;
	logic         out_ff;
	logic         edge_ff;

	// duty latched at period start to avoid glitches
	always_ff @(posedge clk_i) begin
		if (rst_i || !en_i) begin
			duty_ff <= '0;
			out_ff  <= 1'b0;
			edge_ff <= 1'b0;
		end else if (prd_i) begin
			duty_ff <= duty_i;
			out_ff  <= (duty_i != '0);
			edge_ff <= 1'b1;
		end else begin
			edge_ff <= 1'b0;
			if (ptmr_i == duty_ff) begin
				out_ff <= 1'b0;
			end
		end
	end

	assign pwm_o  = out_ff;
	assign edge_o = edge_ff;
endmodule

// ### ccm_unit.sv
/*
 * ccm_unit: mode decoding and behaviour of one capture/compare/pwm unit,
 * with its own 16-bit first timer.
 * assumes: period timer count and period pulse arrive on clk_i; the
 * interrupt flag is cleared by software through int_clr_i.
 */
// Overview of operation
// R1: four-bit mode field selects unit behaviour
// R2: mode 0000 turns off and resets unit; the first timer is not reset and keeps counting
// R3: mode 0011 captures on every input edge
// R4: mode 0100 captures on falling edges only
// R5: mode 0101 captures on rising edges only
// R6: mode 0110 captures every fourth rising edge
// R7: mode 0111 captures every sixteenth rising edge
// R8: mode 0010 toggles output on match, keeps timer
// R9: mode 0001 toggles output, clears first timer
// R10: mode 1000 sets output on match
// R11: mode 1001 clears output on match
// R12: mode 1010 pulses output 0-1-0 on match
// R13: mode 1011 pulses output and clears timer
// R14: modes 1100 and 1111 generate period-timed pwm
// R15: every event sets the interrupt flag
// R16: events trigger adc when unit selected
// R17: first timer is 16-bit up-counter
// R18: capture copies count; match on equal compare
// R19: reserved modes produce no activity
`timescale 1ns/1ps
module ccm_unit #(
	parameter int TMR_W = 16
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// control
	input  wire logic [7:0]       capture_compare_control_i,
	input  wire logic [TMR_W-1:0] compare_value_i,
	input  wire logic             timer_en_i,
	input  wire logic             adc_sel_i,
	input  wire logic             int_clr_i,
	// pins and timers
	input  wire logic             unit_pin_i,
	input  wire logic [TMR_W-1:0] period_timer_i,
	input  wire logic             period_reload_i,
	// status and outputs
	output logic [TMR_W-1:0]      first_timer_count_o,
	output logic [TMR_W-1:0]      capture_hold_o,
	output logic                  unit_out_o,
	output logic                  capture_compare_int_flag_o,
	output logic                  adc_start_o,
	output ccm_pkg::ccm_evt_type  event_o
);
	logic [3:0]             mode;
	ccm_pkg::ccm_dec_type   dec;
	logic                   rise;
	logic                   fall;
	logic [3:0]             pre_ff;
	logic [TMR_W-1:0]       tmr_ff;
	logic [TMR_W-1:0]       hold_ff;
	logic                   out_ff;
	logic                   pls_ff;
	logic                   flag_ff;
	logic                   adc_ff;
	logic                   match_ff;
	logic                   cap_evt;
	logic                   pre_hit;
	logic                   match;
	logic                   pwm_out;
	logic                   pwm_edge;
	logic                   pwm_evt;
	logic                   any_evt;

	// mode field decode
	function automatic ccm_pkg::ccm_dec_type decode(input logic [3:0] m);
		ccm_pkg::ccm_dec_type d;
		d = '{kind: ccm_pkg::CCM_KIND_RSV, cap_rise: 1'b0, cap_fall: 1'b0,
			pre_last: 4'h0, clr_tmr: 1'b0, pulse: 1'b0};
		case (m)
			ccm_pkg::CCM_MODE_OFF:   d.kind = ccm_pkg::CCM_KIND_OFF; // [R2]
			ccm_pkg::CCM_MODE_CAPBO: begin // [R3]
				d.kind     = ccm_pkg::CCM_KIND_CAP;
				d.cap_rise = 1'b1;
				d.cap_fall = 1'b1;
			end
			ccm_pkg::CCM_MODE_CAPFA: begin // [R4]
				d.kind     = ccm_pkg::CCM_KIND_CAP;
				d.cap_fall = 1'b1;
			end
			ccm_pkg::CCM_MODE_CAPRI: begin // [R5]
				d.kind     = ccm_pkg::CCM_KIND_CAP;
				d.cap_rise = 1'b1;
			end
			ccm_pkg::CCM_MODE_CAP4: begin // [R6]
				d.kind     = ccm_pkg::CCM_KIND_CAP;
				d.cap_rise = 1'b1;
				d.pre_last = ccm_pkg::CCM_PRE4_LAST;
			end
			ccm_pkg::CCM_MODE_CAP16: begin // [R7]
				d.kind     = ccm_pkg::CCM_KIND_CAP;
				d.cap_rise = 1'b1;
				d.pre_last = ccm_pkg::CCM_PRE16_LAST;
			end
			ccm_pkg::CCM_MODE_TGL:   d.kind = ccm_pkg::CCM_KIND_CMP; // [R8]
			ccm_pkg::CCM_MODE_TGLCL: begin // [R9]
				d.kind    = ccm_pkg::CCM_KIND_CMP;
				d.clr_tmr = 1'b1;
			end
			ccm_pkg::CCM_MODE_SET:   d.kind = ccm_pkg::CCM_KIND_CMP; // [R10]
			ccm_pkg::CCM_MODE_CLR:   d.kind = ccm_pkg::CCM_KIND_CMP; // [R11]
			ccm_pkg::CCM_MODE_PLS: begin // [R12]
				d.kind  = ccm_pkg::CCM_KIND_CMP;
				d.pulse = 1'b1;
			end
			ccm_pkg::CCM_MODE_PLSCL: begin // [R13]
				d.kind    = ccm_pkg::CCM_KIND_CMP;
				d.pulse   = 1'b1;
				d.clr_tmr = 1'b1;
			end
			ccm_pkg::CCM_MODE_PWM,
			ccm_pkg::CCM_MODE_PWM2:  d.kind = ccm_pkg::CCM_KIND_PWM; // [R14]
			default:                 d.kind = ccm_pkg::CCM_KIND_RSV; // [R19]
		endcase
		return d;
	endfunction

	assign mode = capture_compare_control_i[ccm_pkg::CCM_MODE_LSB +: ccm_pkg::CCM_MODE_W]; // [R1]
	assign dec  = decode(mode);

	ccm_edge u_edge (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.pin_i  (unit_pin_i),
		.rise_o (rise),
		.fall_o (fall)
	);

	ccm_pwm #(
		.W (TMR_W)
	) u_pwm (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.en_i   (dec.kind == ccm_pkg::CCM_KIND_PWM),
		.duty_i (compare_value_i),
		.ptmr_i (period_timer_i),
		.prd_i  (period_reload_i),
		.pwm_o  (pwm_out),
		.edge_o (pwm_edge)
	);

	// capture edge qualification and prescale
	assign pre_hit = (pre_ff == dec.pre_last);
	assign cap_evt = (dec.kind == ccm_pkg::CCM_KIND_CAP)
		&& ((rise && dec.cap_rise) || (fall && dec.cap_fall))
		&& pre_hit; // [R3] [R4] [R5] [R6] [R7]

	always_ff @(posedge clk_i) begin
		if (rst_i || dec.kind != ccm_pkg::CCM_KIND_CAP || dec.pre_last == 4'h0) begin
			pre_ff <= 4'h0;
		end else if (rise) begin
			pre_ff <= pre_hit ? 4'h0 : pre_ff + 4'h1; // [R6] [R7]
		end
	end

	// compare match, only once per equal count
	assign match = (dec.kind == ccm_pkg::CCM_KIND_CMP)
		&& (tmr_ff == compare_value_i) && !match_ff; // [R18]

	always_ff @(posedge clk_i) begin
		if (rst_i || dec.kind != ccm_pkg::CCM_KIND_CMP) begin
			match_ff <= 1'b0;
		end else begin
			match_ff <= (tmr_ff == compare_value_i);
		end
	end

	// first timer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tmr_ff <= TMR_W'(ccm_pkg::CCM_TMR_RST);
		end else if (match && dec.clr_tmr) begin
			tmr_ff <= TMR_W'(ccm_pkg::CCM_TMR_RST); // [R9] [R13]
		end else if (timer_en_i) begin
			tmr_ff <= tmr_ff + TMR_W'(1); // [R17]
		end
	end

	// capture holding register
	always_ff @(posedge clk_i) begin
		if (rst_i || dec.kind == ccm_pkg::CCM_KIND_OFF) begin
			hold_ff <= '0; // [R2]
		end else if (cap_evt) begin
			hold_ff <= tmr_ff; // [R18]
		end
	end

	// compare output
	always_ff @(posedge clk_i) begin
		if (rst_i || dec.kind == ccm_pkg::CCM_KIND_OFF) begin
			out_ff <= 1'b0; // [R2]
			pls_ff <= 1'b0;
		end else begin
			pls_ff <= 1'b0;
			if (match) begin
				case (mode)
					ccm_pkg::CCM_MODE_TGL,
					ccm_pkg::CCM_MODE_TGLCL: out_ff <= ~out_ff; // [R8] [R9]
					ccm_pkg::CCM_MODE_SET:   out_ff <= 1'b1; // [R10]
					ccm_pkg::CCM_MODE_CLR:   out_ff <= 1'b0; // [R11]
					ccm_pkg::CCM_MODE_PLS,
					ccm_pkg::CCM_MODE_PLSCL: pls_ff <= 1'b1; // [R12] [R13]
					default:                 out_ff <= out_ff;
				endcase
			end
		end
	end

	always_comb begin
		case (dec.kind)
			ccm_pkg::CCM_KIND_CMP: unit_out_o = dec.pulse ? pls_ff : out_ff;
			ccm_pkg::CCM_KIND_PWM: unit_out_o = pwm_out; // [R14]
			default:               unit_out_o = 1'b0; // [R19]
		endcase
	end

	// registered period edge may outlive the mode, so gate it
	assign pwm_evt = (dec.kind == ccm_pkg::CCM_KIND_PWM) && pwm_edge; // [R14] [R19]

	// events, interrupt flag, adc trigger
	assign any_evt = cap_evt || match || pwm_evt;

	always_ff @(posedge clk_i) begin
		if (rst_i || dec.kind == ccm_pkg::CCM_KIND_OFF) begin
			flag_ff <= 1'b0;
		end else if (any_evt) begin
			flag_ff <= 1'b1; // [R15]
		end else if (int_clr_i) begin
			flag_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			adc_ff <= 1'b0;
		end else begin
			adc_ff <= any_evt && adc_sel_i; // [R16]
		end
	end

	assign first_timer_count_o        = tmr_ff;
	assign capture_hold_o             = hold_ff;
	assign capture_compare_int_flag_o = flag_ff;
	assign adc_start_o                = adc_ff;
	assign event_o                    = '{capture: cap_evt, match: match, pwm_edge: pwm_evt};

	property p_cap_copy;
		@(posedge clk_i) disable iff (rst_i) cap_evt |=> hold_ff == $past(tmr_ff);
	endproperty
	a_cap_copy: assert property (p_cap_copy) else $error("capture did not copy timer"); // [R18]
	property p_tmr_clr;
		@(posedge clk_i) disable iff (rst_i) (match && dec.clr_tmr) |=> tmr_ff == '0;
	endproperty
	a_tmr_clr: assert property (p_tmr_clr) else $error("timer not cleared on match"); // [R9] [R13]
	property p_flag;
		@(posedge clk_i) disable iff (rst_i) (any_evt && dec.kind != ccm_pkg::CCM_KIND_OFF) |=> flag_ff;
	endproperty
	a_flag: assert property (p_flag) else $error("event did not set flag"); // [R15]
	property p_adc;
		@(posedge clk_i) disable iff (rst_i) (any_evt && adc_sel_i) |=> adc_start_o;
	endproperty
	a_adc: assert property (p_adc) else $error("adc not started"); // [R16]
	property p_off;
		@(posedge clk_i) disable iff (rst_i) (mode == ccm_pkg::CCM_MODE_OFF)[*2] |-> !flag_ff && !unit_out_o;
	endproperty
	a_off: assert property (p_off) else $error("off mode not reset"); // [R2]
	property p_rsv;
		@(posedge clk_i) disable iff (rst_i) (dec.kind == ccm_pkg::CCM_KIND_RSV) |-> !any_evt && !unit_out_o;
	endproperty
	a_rsv: assert property (p_rsv) else $error("activity in reserved mode"); // [R19]
	property p_set;
		@(posedge clk_i) disable iff (rst_i) (match && mode == ccm_pkg::CCM_MODE_SET) ##1
			(mode == ccm_pkg::CCM_MODE_SET) |-> unit_out_o;
	endproperty
	a_set: assert property (p_set) else $error("output not set on match"); // [R10]
	property p_clr;
		@(posedge clk_i) disable iff (rst_i) (match && mode == ccm_pkg::CCM_MODE_CLR) ##1
			(mode == ccm_pkg::CCM_MODE_CLR) |-> !unit_out_o;
	endproperty
	a_clr: assert property (p_clr) else $error("output not cleared on match"); // [R11]
	property p_tgl;
		@(posedge clk_i) disable iff (rst_i) (match && mode == ccm_pkg::CCM_MODE_TGL) ##1
			(mode == ccm_pkg::CCM_MODE_TGL) |-> unit_out_o != $past(unit_out_o);
	endproperty
	a_tgl: assert property (p_tgl) else $error("output not toggled"); // [R8]
	property p_fall_only;
		@(posedge clk_i) disable iff (rst_i) (mode == ccm_pkg::CCM_MODE_CAPFA && rise) |-> !cap_evt;
	endproperty
	a_fall_only: assert property (p_fall_only) else $error("capture on wrong edge"); // [R4]
	property p_rise_only;
		@(posedge clk_i) disable iff (rst_i) (mode == ccm_pkg::CCM_MODE_CAPRI && fall) |-> !cap_evt;
	endproperty
	a_rise_only: assert property (p_rise_only) else $error("capture on falling edge"); // [R5]
	property p_pulse;
		@(posedge clk_i) disable iff (rst_i) (match && dec.pulse) ##1 dec.pulse |-> unit_out_o ##1 !pls_ff;
	endproperty
	a_pulse: assert property (p_pulse) else $error("compare pulse not one cycle"); // [R12] [R13]

	c_cap:   cover property (@(posedge clk_i) cap_evt);
	c_match: cover property (@(posedge clk_i) match && dec.clr_tmr);
	c_pwm:   cover property (@(posedge clk_i) pwm_edge);
	c_pls:   cover property (@(posedge clk_i) pls_ff);
endmodule

// ### tb_capture_compare_mode_select.sv
/*
 * tb_capture_compare_mode_select: self-checking bench for ccm_unit.
 * assumes: ccm_pkg and ccm_far_model compiled first; 40 MHz clock.
 */
`timescale 1ns/1ps
module tb_capture_compare_mode_select;
	localparam int PER = 10;
	logic                 clk_i = 1'b0;
	logic                 rst_i = 1'b1;
	logic [7:0]           ctl   = 8'h00;
	logic [15:0]          cmp   = 16'h0000;
	logic                 ten   = 1'b0;
	logic                 asel  = 1'b1;
	logic                 iclr  = 1'b0;
	logic                 pin   = 1'b0;
	logic [15:0]          tmr   = 16'h0000;
	wire logic [15:0]     ptmr;
	wire logic            prl;
	logic [15:0]          tmr_o;
	logic [15:0]          hold_o;
	logic                 out_o;
	logic                 flag_o;
	logic                 adc_o;
	ccm_pkg::ccm_evt_type event_o;
	int                   mismatches = 0;
	int                   checked = 0;
	int                   ncap = 0;
	int                   nmat = 0;
	int                   nadc = 0;
	int                   nhigh = 0;
	int                   npwm = 0;

	always #12.5 clk_i = ~clk_i;

	ccm_far_model #(.P(PER)) ccm_far_model_i (.clk_i(clk_i), .rst_i(rst_i), .period_timer_o(ptmr),
		.period_reload_o(prl));
	ccm_unit #(.TMR_W(16)) ccm_unit_i (.clk_i(clk_i), .rst_i(rst_i), .capture_compare_control_i(ctl),
		.compare_value_i(cmp), .timer_en_i(ten), .adc_sel_i(asel), .int_clr_i(iclr), .unit_pin_i(pin),
		.period_timer_i(ptmr), .period_reload_i(prl), .first_timer_count_o(tmr_o),
		.capture_hold_o(hold_o), .unit_out_o(out_o), .capture_compare_int_flag_o(flag_o),
		.adc_start_o(adc_o), .event_o(event_o));

	// event tallies, taken mid-cycle where outputs are settled
	always @(negedge clk_i) begin
		ncap += int'(event_o.capture);
		nmat += int'(event_o.match);
		nadc += int'(adc_o);
		nhigh += int'(out_o);
		npwm += int'(event_o.pwm_edge);
	end

	task automatic give_verdict;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#2;
	endtask

	task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_bit(input string what, input logic exp, input logic got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic chk_count(input string what, input int exp, input int got);
		checked++;
		if (got != exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	// pass through off so every mode starts fresh
	task automatic set_mode(input logic [3:0] m);
		ctl = 8'h00;
		cyc(2);
		ctl = {4'h0, m};
		cyc(1);
		ncap = 0;
		nmat = 0;
		nadc = 0;
	endtask

	// 16 full pin pulses, timer frozen
	task automatic cap_run(input logic [3:0] m, input int exp, input logic sel);
		asel = sel;
		set_mode(m);
		repeat (16) begin
			pin = 1'b1;
			cyc(4);
			pin = 1'b0;
			cyc(4);
		end
		cyc(8);
		chk_count("captures", exp, ncap);
		chk_count("adc starts", sel ? exp : 0, nadc);
		chk_bit("flag", exp > 0, flag_o);
		chk_bit("out", 1'b0, out_o);
		if (exp > 0) begin
			chk_word("held count", tmr, hold_o);
		end
		asel = 1'b1;
	endtask

	// match six counts ahead, then look at the cycle after
	task automatic cmp_run(input logic [3:0] m, input logic clr, input logic exp_out, input logic pls);
		int n;
		n = 0;
		cmp = tmr + 16'h0006;
		set_mode(m);
		ten = 1'b1;
		while (event_o.match !== 1'b1 && n < 20) begin
			cyc(1);
			n++;
		end
		chk_count("cycles to match", 6, n);
		cyc(1);
		ten = 1'b0;
		tmr = clr ? 16'h0000 : tmr + 16'h0007;
		chk_bit("out", exp_out, out_o);
		chk_bit("flag", 1'b1, flag_o);
		chk_word("timer", tmr, tmr_o);
		cyc(1);
		chk_count("matches", 1, nmat);
		chk_count("adc starts", 1, nadc);
		if (pls) begin
			chk_bit("out after pulse", 1'b0, out_o);
		end
		iclr = 1'b1;
		cyc(1);
		iclr = 1'b0;
		chk_bit("flag cleared", 1'b0, flag_o);
	endtask

	// high cycles, period edges and adc starts over four whole periods
	task automatic pwm_run(input logic [3:0] m, input logic [15:0] duty, input int exp);
		logic pwm;
		pwm = (m == ccm_pkg::CCM_MODE_PWM) || (m == ccm_pkg::CCM_MODE_PWM2);
		cmp = duty;
		set_mode(m);
		cyc(3 * PER);
		nhigh = 0;
		npwm = 0;
		nadc = 0;
		cyc(4 * PER);
		chk_count("pwm high cycles", 4 * exp, nhigh);
		chk_count("pwm period edges", pwm ? 4 : 0, npwm);
		chk_count("adc starts", pwm ? 4 : 0, nadc);
		chk_bit("flag", pwm, flag_o);
	endtask

	initial begin
		cyc(16);
		rst_i = 1'b0;
		cyc(1);
		chk_word("timer after reset", 16'h0000, tmr_o);
		chk_bit("out after reset", 1'b0, out_o);
		chk_bit("flag after reset", 1'b0, flag_o);
		ten = 1'b1;
		cyc(50);
		ten = 1'b0;
		tmr = 16'h0032;
		cyc(1);
		chk_word("timer count", tmr, tmr_o);
		cap_run(4'h3, 32, 1'b1);
		cap_run(4'h4, 16, 1'b1);
		cap_run(4'h5, 16, 1'b0);
		cap_run(4'h6, 4, 1'b1);
		cap_run(4'hD, 0, 1'b1);
		cap_run(4'hE, 0, 1'b1);
		cap_run(4'h7, 1, 1'b1);
		ctl = 8'h00;
		cyc(2);
		chk_word("hold in off", 16'h0000, hold_o);
		chk_bit("flag in off", 1'b0, flag_o);
		cmp_run(4'h2, 1'b0, 1'b1, 1'b0);
		cmp_run(4'h1, 1'b1, 1'b1, 1'b0);
		cmp_run(4'h8, 1'b0, 1'b1, 1'b0);
		ctl = 8'h00;
		cyc(2);
		chk_bit("out in off", 1'b0, out_o);
		cmp_run(4'h9, 1'b0, 1'b0, 1'b0);
		cmp_run(4'hA, 1'b0, 1'b1, 1'b1);
		cmp_run(4'hB, 1'b1, 1'b1, 1'b1);
		pwm_run(4'hC, 16'h0003, 3);
		pwm_run(4'hF, 16'h0007, 7);
		pwm_run(4'hC, 16'h0000, 0);
		pwm_run(4'hD, 16'h0003, 0);
		pwm_run(4'hE, 16'h0003, 0);
		give_verdict();
	end

	// watchdog
	initial begin
		repeat (20000) @(posedge clk_i);
		mismatches++;
		give_verdict();
	end
endmodule
